// File: design/tnfc_codec.sv
`timescale 1ns/1ps
`include "tnfc_regs.svh"
module tnfc_codec (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic req_in,
  input wire tnfc_pkg::tnfc_dir_t dir_in,
  input wire tnfc_pkg::tnfc_fmt_t fmt_in,
  input wire logic [15:0] word_in,
  input wire logic signed [31:0] val_in,
  input wire logic signed [7:0] exp_in,
  input wire logic cust_signed_in,
  input wire logic signed [15:0] cust_scale_in,
  input wire logic text_last_in,
  output logic ack_out,
  output logic [15:0] word_out,
  output logic signed [31:0] val_out,
  output logic signed [7:0] exp_out,
  output logic sat_out,
  output logic text_last_out
);
  import tnfc_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  logic s1_v_r;
  tnfc_dir_t s1_dir_r;
  tnfc_fmt_t s1_fmt_r;
  logic [15:0] s1_word_r;
  logic signed [31:0] s1_val_r;
  logic signed [7:0] s1_exp_r;
  logic s1_cs_r;
  logic signed [15:0] s1_scale_r;
  logic s1_last_r;
  logic signed [10:0] nm_man;
  logic signed [4:0] nm_exp;
  logic nm_sat;
  logic [15:0] word_nxt;
  logic signed [31:0] val_nxt;
  logic signed [7:0] exp_nxt;
  logic sat_nxt;
  logic signed [31:0] fit;
  // first stage captures the request so the wide arithmetic sees stable data
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      s1_v_r <= 1'b0;
      s1_dir_r <= TNFC_DIR_UNPACK;
      s1_fmt_r <= TNFC_FMT_EXP_MANT;
      s1_word_r <= 16'h0000;
      s1_val_r <= 32'sh00000000;
      s1_exp_r <= 8'sh00;
      s1_cs_r <= 1'b0;
      s1_scale_r <= 16'sh0000;
      s1_last_r <= 1'b0;
    end else begin
      s1_v_r <= req_in;
      if (req_in) begin
        s1_dir_r <= dir_in;
        s1_fmt_r <= fmt_in;
        s1_word_r <= word_in;
        s1_val_r <= val_in;
        s1_exp_r <= exp_in;
        s1_cs_r <= cust_signed_in;
        s1_scale_r <= cust_scale_in;
        s1_last_r <= text_last_in;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  tnfc_norm u_norm (
    .val_in(s1_val_r),
    .exp_in(s1_exp_r),
    .man_out(nm_man),
    .exp_out(nm_exp),
    .sat_out(nm_sat)
  );
  // per-format conversion; unpack yields value and exponent, pack a word
  always_comb begin
    word_nxt = s1_word_r;
    val_nxt = 32'sh00000000;
    exp_nxt = 8'sh00;
    sat_nxt = 1'b0;
    fit = 32'sh00000000;
    unique case (s1_fmt_r)
      TNFC_FMT_EXP_MANT: begin
        if (s1_dir_r == TNFC_DIR_UNPACK) begin
          val_nxt = 32'(signed'(s1_word_r[`TNFC_MAN_MSB:`TNFC_MAN_LSB]));
          exp_nxt = 8'(signed'(s1_word_r[`TNFC_EXP_MSB:`TNFC_EXP_LSB]));
        end else begin
          word_nxt = {nm_exp, nm_man};
          sat_nxt = nm_sat;
        end
      end
      TNFC_FMT_FIXED_EXP: begin
        exp_nxt = 8'(`TNFC_FIXED_EXP);
        if (s1_dir_r == TNFC_DIR_UNPACK) begin
          val_nxt = {16'h0000, s1_word_r};
        end else begin
          // align caller value to the hardwired exponent, then clamp
          fit = s1_val_r <<< (s1_exp_r - exp_nxt);
          if (s1_exp_r < exp_nxt) begin
            fit = s1_val_r >>> (exp_nxt - s1_exp_r);
          end
          if (fit < 0) begin
            word_nxt = 16'h0000;
            sat_nxt = 1'b1;
          end else if (fit > 32'sh0000FFFF) begin
            word_nxt = 16'hFFFF;
            sat_nxt = 1'b1;
          end else begin
            word_nxt = fit[15:0];
          end
        end
      end
      TNFC_FMT_RAW16: begin
        val_nxt = {16'h0000, s1_word_r};
        word_nxt = s1_val_r[15:0];
      end
      TNFC_FMT_RAW8: begin
        val_nxt = {24'h000000, s1_word_r[7:0]};
        word_nxt = {8'h00, s1_val_r[7:0]};
      end
      TNFC_FMT_UWORD: begin
        val_nxt = {16'h0000, s1_word_r};
        word_nxt = s1_val_r[15:0];
      end
      TNFC_FMT_CUSTOM: begin
        // unpack only scales; packing passes the integer through unscaled
        if (s1_cs_r) begin
          val_nxt = 32'(signed'(s1_word_r)) * 32'(s1_scale_r);
        end else begin
          val_nxt = 32'({16'h0000, s1_word_r}) * 32'(s1_scale_r);
        end
        word_nxt = s1_val_r[15:0];
      end
      TNFC_FMT_TEXT: begin
        val_nxt = {24'h000000, s1_word_r[7:0]};
        word_nxt = {8'h00, s1_val_r[7:0]};
      end
      default: begin
        word_nxt = 16'h0000;
      end
    endcase
  end
  ////////////////////////////////////////////////////////////////////////
  // answer register: ack_out follows s1_v_r each cycle; the other outputs hold until the next answer
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      ack_out <= 1'b0;
      word_out <= 16'h0000;
      val_out <= 32'sh00000000;
      exp_out <= 8'sh00;
      sat_out <= 1'b0;
      text_last_out <= 1'b0;
    end else begin
      ack_out <= s1_v_r;
      if (s1_v_r) begin
        word_out <= word_nxt;
        val_out <= val_nxt;
        exp_out <= exp_nxt;
        sat_out <= sat_nxt;
        text_last_out <= (s1_fmt_r == TNFC_FMT_TEXT) && s1_last_r;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  sequence unpack_em_req;
    req_in && dir_in == TNFC_DIR_UNPACK && fmt_in == TNFC_FMT_EXP_MANT;
  endsequence
  chk_em_exp_field: assert property (@(posedge mclk_in) disable iff (srst_in)
    unpack_em_req |-> ##2 exp_out == 8'(signed'($past(word_in[15:11], 2))))
    else $error("exponent field wrong");
  chk_em_man_field: assert property (@(posedge mclk_in) disable iff (srst_in)
    unpack_em_req |-> ##2 val_out == 32'(signed'($past(word_in[10:0], 2))))
    else $error("mantissa field wrong");
  chk_fixed_unpack: assert property (@(posedge mclk_in) disable iff (srst_in)
    req_in && dir_in == TNFC_DIR_UNPACK && fmt_in == TNFC_FMT_FIXED_EXP |->
    ##2 val_out == {16'h0000, $past(word_in, 2)})
    else $error("unsigned mantissa wrong");
  chk_fixed_exp: assert property (@(posedge mclk_in) disable iff (srst_in)
    req_in && fmt_in == TNFC_FMT_FIXED_EXP |-> ##2 exp_out == -8'sd12)
    else $error("fixed exponent not -12");
  chk_raw8_pass: assert property (@(posedge mclk_in) disable iff (srst_in)
    req_in && dir_in == TNFC_DIR_UNPACK && fmt_in == TNFC_FMT_RAW8 |->
    ##2 val_out == {24'h000000, $past(word_in[7:0], 2)})
    else $error("raw byte altered");
  chk_uword_pass: assert property (@(posedge mclk_in) disable iff (srst_in)
    req_in && fmt_in == TNFC_FMT_UWORD |-> ##2 ack_out &&
    val_out == {16'h0000, $past(word_in, 2)})
    else $error("integer word altered");
  chk_custom_scale: assert property (@(posedge mclk_in) disable iff (srst_in)
    req_in && fmt_in == TNFC_FMT_CUSTOM && cust_signed_in |-> ##2
    val_out == 32'(signed'($past(word_in, 2))) * 32'($past(cust_scale_in, 2)))
    else $error("custom scale wrong");
  chk_text_last: assert property (@(posedge mclk_in) disable iff (srst_in)
    req_in && fmt_in == TNFC_FMT_TEXT && text_last_in |-> ##2 text_last_out)
    else $error("text end lost");
  chk_pack_fits: assert property (@(posedge mclk_in) disable iff (srst_in)
    req_in && dir_in == TNFC_DIR_PACK && fmt_in == TNFC_FMT_EXP_MANT &&
    val_in < 32'sd1024 && val_in >= -32'sd1024 && exp_in == 8'sh00 |->
    ##2 word_out == {5'h00, $past(val_in[10:0], 2)})
    else $error("small value not packed exactly");
endmodule : tnfc_codec

// File: design/tnfc_regs.svh
`ifndef TNFC_REGS_SVH
`define TNFC_REGS_SVH
// field positions of the exponent-mantissa word
`define TNFC_EXP_MSB 15
`define TNFC_EXP_LSB 11
`define TNFC_MAN_MSB 10
`define TNFC_MAN_LSB 0
// fixed exponent of the unsigned linear word, two's complement of -12
`define TNFC_FIXED_EXP 5'sh14
// mantissa limits for an eleven-bit signed field
`define TNFC_MAN_MAX 11'sh3FF
`define TNFC_MAN_MIN -11'sh400
// exponent limits for a five-bit signed field
`define TNFC_EXP_MAX 8'sh0F
`define TNFC_EXP_MIN -8'sh10
// latin-1 bytes: all 8-bit codes are legal
`define TNFC_TEXT_W 8
// pipeline depth from request to answer
`define TNFC_LAT 2
`endif

// File: design/tnfc_pkg.sv
package tnfc_pkg;
  // numeric encodings handled by the codec
  typedef enum logic [2:0] {
    TNFC_FMT_EXP_MANT,
    TNFC_FMT_FIXED_EXP,
    TNFC_FMT_RAW16,
    TNFC_FMT_RAW8,
    TNFC_FMT_UWORD,
    TNFC_FMT_CUSTOM,
    TNFC_FMT_TEXT
  } tnfc_fmt_t;
  // direction of a request
  typedef enum logic {
    TNFC_DIR_UNPACK,
    TNFC_DIR_PACK
  } tnfc_dir_t;
endpackage : tnfc_pkg

// File: design/tnfc_norm.sv
`timescale 1ns/1ps
`include "tnfc_regs.svh"
// finds the exponent that packs a 32-bit value into an eleven-bit mantissa
module tnfc_norm (
  input wire logic signed [31:0] val_in,
  input wire logic signed [7:0] exp_in,
  output logic signed [10:0] man_out,
  output logic signed [4:0] exp_out,
  output logic sat_out
);
  logic [4:0] shift;
  logic signed [31:0] shifted;
  logic signed [7:0] e;
  logic signed [31:0] t;
  // smallest right shift that fits keeps the most precision
  always_comb begin
    shift = 5'h00;
    for (int s = 21; s >= 0; s--) begin
      t = val_in >>> s;
      if (t > 32'sd1023 || t < -32'sd1024) begin
        shift = 5'(s + 1);
        break;
      end
    end
    shifted = val_in >>> shift;
    e = exp_in + 8'(shift);
    sat_out = 1'b0;
    if (e > `TNFC_EXP_MAX) begin
      e = `TNFC_EXP_MAX;
      sat_out = 1'b1;
      shifted = (val_in < 0) ? -32'sd1024 : 32'sd1023;
    end else if (e < `TNFC_EXP_MIN) begin
      e = `TNFC_EXP_MIN;
      sat_out = 1'b1;
    end
    man_out = shifted[10:0];
    exp_out = e[4:0];
  end
endmodule : tnfc_norm

// File: sim/tnfc_cmd_model.sv
`timescale 1ns/1ps
// command-side stand-in: one request at a time, each answer awaited
module tnfc_cmd_model (
  input wire logic mclk_in,
  input wire logic ack_in,
  output logic req_out,
  output tnfc_pkg::tnfc_dir_t dir_out,
  output tnfc_pkg::tnfc_fmt_t fmt_out,
  output logic [15:0] word_out,
  output logic signed [31:0] val_out,
  output logic signed [7:0] exp_out,
  input wire logic cust_signed_in,
  input wire logic signed [15:0] cust_scale_in,
  input wire logic text_last_in,
  output logic cust_signed_out,
  output logic signed [15:0] cust_scale_out,
  output logic text_last_out
);
  import tnfc_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  // idle values at time zero
  initial begin
    {req_out, word_out, val_out, exp_out} = '0;
    {cust_signed_out, cust_scale_out, text_last_out} = '0;
    dir_out = TNFC_DIR_UNPACK;
    fmt_out = TNFC_FMT_EXP_MANT;
  end
  // strobe for one cycle, hold the qualifiers until the answer edge;
  // n returns the edges from take to answer, bounded so a hang shows
  task automatic send(input tnfc_dir_t d, input tnfc_fmt_t f,
    input logic [15:0] w, input logic signed [31:0] v,
    input logic signed [7:0] e, output int n);
    @(posedge mclk_in);
    #1;
    req_out = 1'b1;
    dir_out = d;
    fmt_out = f;
    word_out = w;
    val_out = v;
    exp_out = e;
    cust_signed_out = cust_signed_in;
    cust_scale_out = cust_scale_in;
    text_last_out = text_last_in;
    @(posedge mclk_in);
    #1;
    req_out = 1'b0;
    // the take edge has passed, so counting starts at one
    for (n = 1; n < 20 && ack_in !== 1'b1; n++) begin
      @(posedge mclk_in);
      #1;
    end
    // released data lines must not keep the old value
    word_out = ~word_out;
    val_out = ~val_out;
  endtask : send
endmodule : tnfc_cmd_model

// File: sim/tb_tnfc_codec.sv
`timescale 1ns/1ps
module tb_tnfc_codec;
  import tnfc_pkg::*;
  logic mclk_in = 1'b0;
  logic srst_in = 1'b1;
  logic req, ack, cs, tl, sat, tlo, c_sig, t_last;
  tnfc_dir_t dir;
  tnfc_fmt_t fmt;
  logic [15:0] word, wout;
  logic signed [31:0] val, vout;
  logic signed [7:0] ex, exo;
  logic signed [15:0] sc, c_scale;
  int err_total = 0;
  int cmp_count = 0;
  // 40 MHz clock
  always #12.5 mclk_in = ~mclk_in;
  tnfc_codec u_tnfc_codec (.mclk_in(mclk_in), .srst_in(srst_in),
    .req_in(req), .dir_in(dir), .fmt_in(fmt), .word_in(word),
    .val_in(val), .exp_in(ex), .cust_signed_in(cs), .cust_scale_in(sc),
    .text_last_in(tl), .ack_out(ack), .word_out(wout), .val_out(vout),
    .exp_out(exo), .sat_out(sat), .text_last_out(tlo));
  tnfc_cmd_model u_tnfc_cmd_model (.mclk_in(mclk_in), .ack_in(ack),
    .req_out(req), .dir_out(dir), .fmt_out(fmt), .word_out(word),
    .val_out(val), .exp_out(ex), .cust_signed_in(c_sig),
    .cust_scale_in(c_scale), .text_last_in(t_last),
    .cust_signed_out(cs), .cust_scale_out(sc), .text_last_out(tl));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      err_total++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, want);
    end
  endtask : chk
  // one request; the answer must land on the first edge after the take
  task automatic run(input tnfc_dir_t d, input tnfc_fmt_t f,
    input logic [15:0] w, input logic signed [31:0] v,
    input logic signed [7:0] e);
    int n;
    u_tnfc_cmd_model.send(d, f, w, v, e, n);
    chk(n, 32'h2);
  endtask : run
  task automatic t_exp_unpack;
    run(TNFC_DIR_UNPACK, TNFC_FMT_EXP_MANT, 16'h9807, 32'h0, 8'h00);
    chk({24'h000000, exo}, 32'h000000F3);
    chk(vout, 32'h00000007);
    run(TNFC_DIR_UNPACK, TNFC_FMT_EXP_MANT, 16'h8400, 32'h0, 8'h00);
    chk({24'h000000, exo}, 32'h000000F0);
    chk(vout, 32'hFFFFFC00);
  endtask : t_exp_unpack
  task automatic t_fixed;
    run(TNFC_DIR_UNPACK, TNFC_FMT_FIXED_EXP, 16'hFFFF, 32'h0, 8'h00);
    chk(vout, 32'h0000FFFF);
    chk({24'h000000, exo}, 32'h000000F4);
    run(TNFC_DIR_PACK, TNFC_FMT_FIXED_EXP, 16'h0, 32'h4C00, 8'hF4);
    chk({wout, 15'h0, sat}, 32'h4C000000);
    run(TNFC_DIR_PACK, TNFC_FMT_FIXED_EXP, 16'h0, 32'h13, 8'h00);
    chk({wout, 15'h0, sat}, 32'hFFFF0001);
    run(TNFC_DIR_PACK, TNFC_FMT_FIXED_EXP, 16'h0, 32'hFFFFFFFF, 8'hF4);
    chk({wout, 15'h0, sat}, 32'h00000001);
  endtask : t_fixed
  task automatic t_raw_uword;
    run(TNFC_DIR_UNPACK, TNFC_FMT_RAW16, 16'h9807, 32'h0, 8'h00);
    chk(vout, 32'h00009807);
    run(TNFC_DIR_UNPACK, TNFC_FMT_RAW8, 16'h12A5, 32'h0, 8'h00);
    chk(vout, 32'h000000A5);
    run(TNFC_DIR_PACK, TNFC_FMT_RAW16, 16'h0, 32'h1234ABCD, 8'h00);
    chk({16'h0000, wout}, 32'h0000ABCD);
    run(TNFC_DIR_PACK, TNFC_FMT_RAW8, 16'h0, 32'h1234ABCD, 8'h00);
    chk({16'h0000, wout}, 32'h000000CD);
    run(TNFC_DIR_PACK, TNFC_FMT_UWORD, 16'h0, 32'h00019807, 8'h00);
    chk({16'h0000, wout}, 32'h00009807);
    run(TNFC_DIR_UNPACK, TNFC_FMT_UWORD, 16'h9807, 32'h0, 8'h00);
    chk({vout[23:0], exo}, 32'h00980700);
  endtask : t_raw_uword
  task automatic t_custom_text;
    c_sig = 1'b1;
    run(TNFC_DIR_UNPACK, TNFC_FMT_CUSTOM, 16'hFFFE, 32'h0, 8'h00);
    chk(vout, 32'hFFFFFFFA);
    c_sig = 1'b0;
    run(TNFC_DIR_UNPACK, TNFC_FMT_CUSTOM, 16'hFFFE, 32'h0, 8'h00);
    chk(vout, 32'h0002FFFA);
    run(TNFC_DIR_UNPACK, TNFC_FMT_TEXT, 16'h00E9, 32'h0, 8'h00);
    chk({vout[7:0], 23'h0, tlo}, 32'hE9000000);
    t_last = 1'b1;
    run(TNFC_DIR_UNPACK, TNFC_FMT_TEXT, 16'h00FF, 32'h0, 8'h00);
    chk({vout[7:0], 23'h0, tlo}, 32'hFF000001);
    run(TNFC_DIR_PACK, TNFC_FMT_TEXT, 16'h0, 32'h000001C4, 8'h00);
    chk({16'h0000, wout}, 32'h000000C4);
    run(TNFC_DIR_PACK, TNFC_FMT_CUSTOM, 16'h0, 32'h00015678, 8'h00);
    chk({16'h0000, wout}, 32'h00005678);
  endtask : t_custom_text
  // 2048 needs two shifts, -1025 just one; a huge value clamps the exponent
  task automatic t_exp_pack;
    run(TNFC_DIR_PACK, TNFC_FMT_EXP_MANT, 16'h0, 32'h7, 8'hF3);
    chk({wout, 15'h0, sat}, 32'h98070000);
    run(TNFC_DIR_PACK, TNFC_FMT_EXP_MANT, 16'h0, 32'h800, 8'h00);
    chk({wout, 15'h0, sat}, 32'h12000000);
    run(TNFC_DIR_PACK, TNFC_FMT_EXP_MANT, 16'h0, 32'hFFFFFBFF, 8'h00);
    chk({wout, 15'h0, sat}, 32'h0DFF0000);
    run(TNFC_DIR_PACK, TNFC_FMT_EXP_MANT, 16'h0, 32'h7FFFFFFF, 8'h0F);
    chk({wout, 15'h0, sat}, 32'h7BFF0001);
  endtask : t_exp_pack
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////
  // main sequence after six reset cycles
  initial begin
    c_sig = 1'b0;
    c_scale = 16'h0003;
    t_last = 1'b0;
    repeat (6) @(posedge mclk_in);
    #1;
    srst_in = 1'b0;
    chk({31'h0, ack}, 32'h0);
    t_exp_unpack();
    t_fixed();
    t_raw_uword();
    t_custom_text();
    t_exp_pack();
    give_verdict();
  end
  // watchdog: the sequence needs well under 200 cycles
  initial begin
    #(25 * 3000);
    err_total++;
    give_verdict();
  end
endmodule : tb_tnfc_codec
